// ### lsd_decoder.sv
// Standard instruction decoder of a character LCD controller with an AXI4-Lite slave.
// Assumes one 25 MHz clock, a synchronous active-low reset, and a master keeping AXI rules.
`timescale 1ns/1ps
`include "lsd_defines.svh"

// Function
// - Home clears counter and shift, keeps modes
// - Entry mode sets direction and shift flags
// - RAM access steps counter by direction
// - Glyph RAM access hides cursor and blink
// - Text write shifts display when enabled
// - No shift on reads or glyph access
// - Display control sets on, cursor, blink
// - Display off: segments low, generators off
// - Outputs low three cycles after off
// - Instructions still run while powered down
// - Cursor is five dots on row eight
// - Blink toggles every 26112 clocks
// - Shift instruction selects target and direction
// - Shift touches no RAM data
// - Cursor wraps after position 40 per line
// - Display shift keeps counter; cursor steps it
// - Glyph address loads low six bits only
// - One shared seven-bit counter, fully readable
// - Bit seven loads text address, selects text
// - Decode only while set-select bit clear
// - Status read gives busy and counter
module lsd_decoder (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output lsd_pkg::lsd_drive_t drive,
    output logic [6:0] cursor_addr,
    output logic [6:0] display_shift
);
    import lsd_pkg::*;

    lsd_state_t state;
    lsd_mode_t mode;
    logic [6:0] addr_counter;
    logic [6:0] shift_count;
    logic glyph_sel;
    logic ext_set;
    logic busy;
    logic [7:0] cmd;
    logic cmd_is_data;
    logic data_is_read;
    logic [3:0] exec_cnt;
    logic [1:0] off_cnt;
    logic [15:0] blink_cnt;
    logic blink_phase;
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic accept;
    logic wr_cmd;
    logic wr_data;
    logic wr_ok;
    // One-cycle execute strobes, one per instruction kind
    logic run_data;
    logic run_text_load;
    logic run_glyph_load;
    logic run_shift;
    logic run_disp;
    logic run_entry;
    logic run_home;

    assign wr_ok = aw_held && w_held && !s_axi_bvalid;
    assign wr_cmd = wr_ok && aw_addr == `LSD_REG_CMD && w_strb[0];
    assign wr_data = wr_ok && aw_addr == `LSD_REG_DATA_OP && w_strb[0];
    assign accept = (wr_cmd || wr_data) && !busy && !ext_set;

    // Strobes fire in the done cycle whatever the display state
    assign run_data = state == lsd_done && cmd_is_data;
    assign run_text_load = state == lsd_done && !cmd_is_data && cmd[7];
    assign run_glyph_load = state == lsd_done && !cmd_is_data && cmd[7:6] == `LSD_PAT_GLYPH;
    assign run_shift = state == lsd_done && !cmd_is_data && cmd[7:4] == `LSD_PAT_SHIFT &&
        cmd[1:0] == 2'h0;
    assign run_disp = state == lsd_done && !cmd_is_data && cmd[7:3] == `LSD_PAT_DISP;
    assign run_entry = state == lsd_done && !cmd_is_data && cmd[7:2] == `LSD_PAT_ENTRY;
    assign run_home = state == lsd_done && !cmd_is_data && cmd == `LSD_CODE_HOME;

    // Step in the given direction, wrapping each 40-position line of text RAM only
    function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up, input logic g);
        logic [6:0] r;
        r = up ? a + 7'h01 : a - 7'h01;
        if (!g) begin
            if (up && a == `LSD_LINE_LEN - 7'h01) begin
                r = `LSD_LINE2_BASE;
            end else if (up && a == `LSD_LINE2_BASE + `LSD_LINE_LEN - 7'h01) begin
                r = 7'h00;
            end else if (!up && a == `LSD_LINE2_BASE) begin
                r = `LSD_LINE_LEN - 7'h01;
            end else if (!up && a == 7'h00) begin
                r = `LSD_LINE2_BASE + `LSD_LINE_LEN - 7'h01;
            end
        end
        return r;
    endfunction

    // Write channel capture, either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_ok) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LSD_RESP_OKAY;
        end else if (wr_ok) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr == `LSD_REG_CMD || aw_addr == `LSD_REG_DATA_OP ||
                aw_addr == `LSD_REG_CTRL) begin
                s_axi_bresp <= `LSD_RESP_OKAY;
            end else begin
                s_axi_bresp <= `LSD_RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control register: instruction set select
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_set <= 1'b0;
        end else if (wr_ok && aw_addr == `LSD_REG_CTRL && w_strb[0]) begin
            ext_set <= w_data[0];
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `LSD_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `LSD_RESP_OKAY;
                case (s_axi_araddr)
                    `LSD_REG_STATUS: s_axi_rdata <= {24'h000000, busy, addr_counter};
                    `LSD_REG_CTRL: s_axi_rdata <= {31'h0000_0000, ext_set};
                    `LSD_REG_STATE: s_axi_rdata <= {16'h0000, shift_count, glyph_sel,
                        3'h0, mode};
                    `LSD_REG_BLINK: s_axi_rdata <= {31'h0000_0000, blink_phase};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `LSD_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Instruction latch: byte and access kind held for the whole execution
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd <= 8'h00;
            cmd_is_data <= 1'b0;
            data_is_read <= 1'b0;
        end else if (state == lsd_idle && accept) begin
            cmd <= w_data[7:0];
            cmd_is_data <= wr_data;
            data_is_read <= w_data[8];
        end
    end

    // Busy sequencer: accepted instruction runs for a fixed time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= lsd_idle;
            busy <= 1'b0;
            exec_cnt <= 4'h0;
        end else begin
            case (state)
                lsd_idle: begin
                    if (accept) begin
                        state <= lsd_exec;
                        busy <= 1'b1;
                        exec_cnt <= `LSD_EXEC_CYCLES;
                    end
                end
                lsd_exec: begin
                    exec_cnt <= exec_cnt - 4'h1;
                    if (exec_cnt == 4'h1) begin
                        state <= lsd_done;
                    end
                end
                lsd_done: begin
                    state <= lsd_idle;
                    busy <= 1'b0;
                end
                default: begin
                    state <= lsd_idle;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    // Display control and entry mode flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= '{disp_on: 1'b0, cursor_on: 1'b0, blink_on: 1'b0,
                addr_inc: 1'b1, shift_on: 1'b0};
        end else if (run_disp) begin
            mode.disp_on <= cmd[2];
            mode.cursor_on <= cmd[1];
            mode.blink_on <= cmd[0];
        end else if (run_entry) begin
            mode.addr_inc <= cmd[1];
            mode.shift_on <= cmd[0];
        end
    end

    // Which RAM later data accesses go to
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            glyph_sel <= 1'b0;
        end else if (run_text_load) begin
            glyph_sel <= 1'b0;
        end else if (run_glyph_load) begin
            glyph_sel <= 1'b1;
        end
    end

    // Shared address counter of both RAMs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_counter <= 7'h00;
        end else if (run_data) begin
            addr_counter <= step_addr(addr_counter, mode.addr_inc, glyph_sel);
        end else if (run_text_load) begin
            addr_counter <= cmd[6:0];
        end else if (run_glyph_load) begin
            addr_counter[5:0] <= cmd[5:0];
        end else if (run_shift && !cmd[3]) begin
            addr_counter <= step_addr(addr_counter, cmd[2], glyph_sel);
        end else if (run_home) begin
            addr_counter <= 7'h00;
        end
    end

    // Display shift offset; a left shift counts up
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_count <= 7'h00;
        end else if (run_data && mode.shift_on && !glyph_sel && !data_is_read) begin
            shift_count <= mode.addr_inc ? shift_count + 7'h01 : shift_count - 7'h01;
        end else if (run_shift && cmd[3]) begin
            shift_count <= cmd[2] ? shift_count - 7'h01 : shift_count + 7'h01;
        end else if (run_home) begin
            shift_count <= 7'h00;
        end
    end

    // Blink timebase
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_cnt <= 16'h0000;
            blink_phase <= 1'b0;
        end else if (blink_cnt == 16'((`LSD_BLINK_DIV / 2) - 1)) begin
            blink_cnt <= 16'h0000;
            blink_phase <= !blink_phase;
        end else begin
            blink_cnt <= blink_cnt + 16'h0001;
        end
    end

    // Display-off counter, counting up; the drivers fall once it reaches its end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            off_cnt <= 2'h0;
        end else if (mode.disp_on) begin
            off_cnt <= 2'h0;
        end else if (off_cnt != `LSD_OFF_CYCLES - 2'h1) begin
            off_cnt <= off_cnt + 2'h1;
        end
    end

    // Power-down levels: drivers fall three cycles after display off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive <= '{seg_low: 1'b1, gen_off: 1'b1, cursor_shown: 1'b0,
                blink_all_dots: 1'b0};
        end else begin
            if (mode.disp_on) begin
                drive.seg_low <= 1'b0;
                drive.gen_off <= 1'b0;
            end else if (off_cnt == `LSD_OFF_CYCLES - 2'h1) begin
                drive.seg_low <= 1'b1;
                drive.gen_off <= 1'b1;
            end
            drive.cursor_shown <= mode.cursor_on && !glyph_sel && mode.disp_on;
            drive.blink_all_dots <= mode.blink_on && !glyph_sel && blink_phase && mode.disp_on;
        end
    end

    // Address counter copy for the row/column engine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cursor_addr <= 7'h00;
        end else begin
            cursor_addr <= addr_counter;
        end
    end

    // Display offset copy for the row/column engine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            display_shift <= 7'h00;
        end else begin
            display_shift <= shift_count;
        end
    end
endmodule

// ### lsd_defines.svh
// Constants of the LCD standard instruction decoder: register map, codes, timing.
// Assumes inclusion by the top module only.
`ifndef LSD_DEFINES_SVH
`define LSD_DEFINES_SVH
`define LSD_REG_CMD 8'h00
`define LSD_REG_DATA_OP 8'h04
`define LSD_REG_CTRL 8'h08
`define LSD_REG_STATUS 8'h0c
`define LSD_REG_STATE 8'h10
`define LSD_REG_BLINK 8'h14
`define LSD_CODE_HOME 8'h02
`define LSD_PAT_ENTRY 6'h01
`define LSD_PAT_DISP 5'h01
`define LSD_PAT_SHIFT 4'h1
`define LSD_PAT_GLYPH 2'h1
`define LSD_LINE_LEN 7'h28
`define LSD_LINE2_BASE 7'h40
`define LSD_OFF_CYCLES 2'h3
`define LSD_BLINK_DIV 52224
`define LSD_EXEC_CYCLES 4'h2
`define LSD_RESP_OKAY 2'h0
`define LSD_RESP_SLVERR 2'h2
`endif

// ### lsd_pkg.sv
// Types of the LCD standard instruction decoder.
// Assumes lsd_defines.svh for the numbers.
package lsd_pkg;
    typedef enum logic [1:0] {lsd_idle, lsd_exec, lsd_done} lsd_state_t;
    typedef struct packed {
        logic disp_on;
        logic cursor_on;
        logic blink_on;
        logic addr_inc;
        logic shift_on;
    } lsd_mode_t;
    typedef struct packed {
        logic seg_low;
        logic gen_off;
        logic cursor_shown;
        logic blink_all_dots;
    } lsd_drive_t;
endpackage

// ### lsd_properties.sv
// Checker for the LCD instruction decoder's port relations.
// Assumes it is bound to lsd_decoder and sees only its ports.
`timescale 1ns/1ps
module lsd_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire lsd_pkg::lsd_drive_t drive,
    input wire logic [6:0] cursor_addr,
    input wire logic [6:0] display_shift
);
    import lsd_pkg::*;
    // Cycles since the last write response; state may change only shortly after one
    logic [3:0] since_b;
    always_ff @(posedge aclk) begin
        if (!aresetn || (s_axi_bvalid && s_axi_bready)) begin
            since_b <= 4'h0;
        end else if (since_b != 4'hf) begin
            since_b <= since_b + 4'h1;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_write_okay: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr <= 8'h08 |-> ##[1:3] (s_axi_bvalid && s_axi_bresp == 2'h0))
        else $error("write not answered with okay");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_off_pair: assert property (drive.seg_low == drive.gen_off)
        else $error("segments and generators disagree");
    a_cursor_gate: assert property (drive.cursor_shown |-> !drive.seg_low && !drive.blink_all_dots || !drive.seg_low)
        else $error("cursor shown while powered down");
    a_blink_gate: assert property (drive.blink_all_dots |-> !drive.seg_low)
        else $error("blink shown while powered down");
    a_shift_step: assert property (!$stable(display_shift) |-> display_shift == $past(display_shift) + 7'h01 || display_shift == $past(display_shift) - 7'h01 || display_shift == 7'h00)
        else $error("display shift jumped");
    a_change_cause: assert property (!$stable(cursor_addr) || !$stable(display_shift) || $rose(drive.seg_low) |-> since_b <= 4'hc)
        else $error("state changed without an instruction");
endmodule
bind lsd_decoder lsd_checker chk_i (.*);

// ### lsd_host.sv
// Host model: AXI4-Lite master that issues instructions to the decoder.
// Assumes the bench calls wr and rd one at a time after reset release.
`timescale 1ns/1ps
module lsd_host (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_araddr, s_axi_arvalid} = '0;
        s_axi_wstrb = 4'hf;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        do @(posedge aclk); while (!s_axi_bvalid);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
endmodule

// ### test_lsd_standard_instruction_decoder.sv
// Bench: random and corner instruction sequences through the host model.
// Assumes lsd_host and lsd_checker are compiled with it.
`timescale 1ns/1ps
module test_lsd_standard_instruction_decoder;
    import lsd_pkg::*;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_d, st;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, m;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    lsd_drive_t drive;
    logic [6:0] cursor_addr, display_shift, a, ea, ac;
    logic [5:0] g;
    logic op, gl;
    int num_errors, checked, cyc, i;
    lsd_decoder uut (.*);
    lsd_host host (.*);
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Write, then poll status until the instruction has finished
    task automatic put(input logic [7:0] ad, input logic [31:0] d);
        int n;
        host.wr(ad, d);
        for (n = 0; n < 20; n++) begin
            host.rd(8'h0c, rd_d, rd_r);
            if (rd_d[7] === 1'b0) break;
        end
    endtask
    task automatic look();
        host.rd(8'h10, st, rd_r);
        host.rd(8'h0c, rd_d, rd_r);
        ac = rd_d[6:0];
        chk(cursor_addr, {25'h0, ac});
    endtask
    function automatic logic [6:0] step(input logic [6:0] x, input logic inc, input logic txt);
        if (!txt) return inc ? x + 7'h01 : x - 7'h01;
        if (inc) return x == 7'h27 ? 7'h40 : x == 7'h67 ? 7'h00 : x + 7'h01;
        return x == 7'h40 ? 7'h27 : x == 7'h00 ? 7'h67 : x - 7'h01;
    endfunction
    initial begin
        aresetn = 1'b0;
        void'($urandom(32'hf98d));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk(drive, 4'hc);
        look();
        chk(st, 32'h2);
        host.rd(8'h18, rd_d, rd_r);
        chk(rd_r, 2'h2);
        for (i = 0; i < 8; i++) begin
            put(8'h00, 32'h08 | i);
            look();
            chk(st[4:2], i[2:0]);
        end
        chk(drive[3:2], 2'b00);
        put(8'h00, 32'h08);
        repeat (3) @(posedge aclk);
        chk(drive[3:2], 2'b11);
        put(8'h00, 32'h85);
        look();
        chk(ac, 7'h05);
        put(8'h00, 32'h0f);
        chk(drive[3:2], 2'b00);
        host.wr(8'h00, 32'h02);
        host.rd(8'h0c, rd_d, rd_r);
        chk(rd_d[7], 1'b1);
        put(8'h08, 32'h1);
        put(8'h00, 32'h91);
        look();
        chk(ac, 7'h00);
        put(8'h08, 32'h0);
        put(8'h00, 32'ha7);
        put(8'h00, 32'h14);
        look();
        chk(ac, 7'h40);
        for (i = 0; i < 16; i++) begin
            a = 7'($urandom % 40 + 64 * ($urandom % 2));
            {g, m, op, gl} = 10'($urandom);
            put(8'h00, 32'h02);
            put(8'h00, 32'h18);
            put(8'h00, {25'h1, a});
            if (gl) put(8'h00, {26'h1, g});
            ea = gl ? {a[6], g} : a;
            look();
            chk({st[15:9], ac}, {7'h01, ea});
            put(8'h00, {30'h1, m});
            put(8'h04, {23'h0, op, 8'h0});
            ea = step(ea, m[1], !gl);
            look();
            chk({st[8], st[1:0], ac}, {gl, m, ea});
            chk(st[15:9], (m[0] && !op && !gl) ? {5'h0, m[1], 1'b0} : 7'h01);
            chk(drive[1], !gl);
        end
        put(8'h00, 32'h02);
        look();
        chk({st[15:9], st[1:0], ac}, {7'h00, m, 7'h00});
        print_verdict();
    end
endmodule
